// ---- include/idrc_pkg.sv ----
// Constants, field layout and state codes of the input driven register copy engine.
// Assumes one 100 MHz clock and a 256 word motor register space of 32-bit words.
`default_nettype none

package idrc_pkg;

	localparam int DATA_W = 32;
	localparam int REG_NUM_W = 8;
	localparam int REG_COUNT = 256;
	localparam int DIN_W = 16;
	localparam int DIN_SEL_W = 4;
	localparam int RULE_COUNT = 12;
	localparam int RULE_IDX_W = 4;
	localparam int APB_ADDR_W = 10;
	localparam int APB_WORD_LSB = 2;

	// Register indexes; the byte address is four times the index
	localparam logic [REG_NUM_W-1:0] RULE_BASE_REG = 8'h5d;
	localparam logic [REG_NUM_W-1:0] DIN_STATE_REG = 8'h6a;
	localparam logic [REG_NUM_W-1:0] NO_REG = 8'h00;
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

	// Rule word fields
	localparam int DEST_MSB = 31;
	localparam int DEST_LSB = 24;
	localparam int SRC_HI_MSB = 23;
	localparam int SRC_HI_LSB = 16;
	localparam int SRC_LO_MSB = 15;
	localparam int SRC_LO_LSB = 8;
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam int TGT_MSB = 3;
	localparam int TGT_LSB = 0;

	typedef enum logic [3:0] {
		TGT_NONE = 4'h0,
		TGT_MODE = 4'h1,
		TGT_VELOCITY = 4'h2,
		TGT_POSITION = 4'h3,
		TGT_ACCEL = 4'h4,
		TGT_TORQUE = 4'h5,
		TGT_INPOS_WIN = 4'h6,
		TGT_ANY_REG = 4'h7
	} idrc_target_t;

	// Fixed target register for codes one to six
	localparam logic [REG_NUM_W-1:0] MODE_REG = 8'h02;
	localparam logic [REG_NUM_W-1:0] VELOCITY_SETPOINT_REG = 8'h05;
	localparam logic [REG_NUM_W-1:0] POSITION_SETPOINT_REG = 8'h03;
	localparam logic [REG_NUM_W-1:0] ACCEL_SETPOINT_REG = 8'h06;
	localparam logic [REG_NUM_W-1:0] TORQUE_SETPOINT_REG = 8'h07;
	localparam logic [REG_NUM_W-1:0] IN_POSITION_WINDOW_REG = 8'h21;

	// Register named by index one of each source group
	localparam logic [REG_NUM_W-1:0] MODE_GROUP_FIRST = 8'h40;
	localparam logic [REG_NUM_W-1:0] VELOCITY_GROUP_FIRST = 8'h48;
	localparam logic [REG_NUM_W-1:0] POSITION_GROUP_FIRST = 8'h50;
	localparam logic [REG_NUM_W-1:0] ACCEL_GROUP_FIRST = 8'h70;
	localparam logic [REG_NUM_W-1:0] TORQUE_GROUP_FIRST = 8'h78;
	localparam logic [REG_NUM_W-1:0] IN_POS_WIN_GROUP_FIRST = 8'h80;

	localparam int CLK_PERIOD_NS = 10;
	localparam int PASS_PERIOD_NS = 1300000;
	localparam int PASS_PERIOD_CYCLES = PASS_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_DECODE = 2'b10,
		ST_COPY = 2'b11
	} idrc_state_t;

endpackage

`default_nettype wire

// ---- rtl/idrc_reg_mem.sv ----
// Motor register space: one registered read port and one write port.
// Assumes the caller never needs read-after-write in the same cycle.
`default_nettype none

module idrc_reg_mem
	import idrc_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = REG_COUNT,
	parameter int ADDR_W = REG_NUM_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// All words, the copy rules among them, clear to zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				mem[i] <= '0;
			end
		end
		else if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

`default_nettype wire

// ---- rtl/idrc_pass_timer.sv ----
// Periodic tick that starts each evaluation pass.
// Assumes PERIOD is at least two cycles.
`default_nettype none

module idrc_pass_timer
	import idrc_pkg::*;
#(
	parameter int PERIOD = PASS_PERIOD_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);

	localparam int CNT_W = $clog2(PERIOD);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

	logic [CNT_W-1:0] count;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			tick <= 1'b0;
		end
		else if (count == LAST)
		begin
			count <= '0;
			tick <= 1'b1;
		end
		else
		begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- rtl/idrc_copy_engine.sv ----
// Input driven register copy engine with its APB register port.
// Assumes an APB3 master on pclk and asynchronous digital input pins.
//
// Notes on behaviour
// - Top byte names the destination register, used only for target code seven.
// - Second-highest byte gives the source used when the selected input is one.
// - Second byte gives the source used when the selected input is zero.
// - Bits seven to four pick the governing bit of the input state register.
// - Low nibble: 0 none, 1-6 fixed targets, 7 register named by top byte.
// - For codes one to six sources are indexes into the target's group.
// - For code seven sources are full register numbers one to 254; the code also takes 255.
// - A zero source, index or destination means no copy, target untouched.
// - All twelve rules run every 1.3 ms in ascending order.
// - No register access interleaves a pass; inputs and registers stay constant.
// - Later rules overwrite earlier ones on the same target.
// - Any rule may use any input, several rules the same one.
// - Each rule copies the source picked by the input level into the target.
// - Levels, not edges, are acted on; a held input reapplies each pass.
//
// The implementer's own choice: register access over APB.
`default_nettype none

module idrc_copy_engine
	import idrc_pkg::*;
#(
	parameter int PASS_CYCLES = PASS_PERIOD_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [DIN_W-1:0] digital_inputs,
	output logic pass_active
);

	idrc_state_t state;
	idrc_state_t next_state;
	logic pass_tick;
	logic [DIN_W-1:0] din_meta;
	logic [DIN_W-1:0] din_sync;
	logic [DIN_W-1:0] input_snap;
	logic [RULE_IDX_W-1:0] rule_idx;
	logic [REG_NUM_W-1:0] copy_dst;
	logic copy_from_inputs;
	logic addr_from_apb;
	logic apb_ack_now;
	logic [REG_NUM_W-1:0] apb_reg;
	logic [REG_NUM_W-1:0] mem_rd_addr;
	logic [DATA_W-1:0] mem_rd_data;
	logic mem_wr_en;
	logic [REG_NUM_W-1:0] mem_wr_addr;
	logic [DATA_W-1:0] mem_wr_data;
	logic [DATA_W-1:0] din_word;
	logic selected_input_level;
	logic [REG_NUM_W-1:0] src_field;
	logic [REG_NUM_W-1:0] dest_field;
	logic [TGT_MSB-TGT_LSB:0] tgt_code;
	logic [REG_NUM_W-1:0] group_first;
	logic [REG_NUM_W-1:0] src_addr;
	logic [REG_NUM_W-1:0] dst_addr;
	logic copy_valid;
	logic last_rule;

	idrc_pass_timer #(
		.PERIOD(PASS_CYCLES)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tick(pass_tick)
	);

	idrc_reg_mem #(
		.WIDTH(DATA_W),
		.DEPTH(REG_COUNT),
		.ADDR_W(REG_NUM_W)
	) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd_data),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data)
	);

	// Two-flop synchroniser for the input pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			din_meta <= '0;
			din_sync <= '0;
		end
		else
		begin
			din_meta <= digital_inputs;
			din_sync <= din_meta;
		end
	end

	assign din_word = {{(DATA_W-DIN_W){1'b0}}, din_sync};
	assign apb_reg = paddr[APB_WORD_LSB +: REG_NUM_W];

	// Input state frozen for the whole pass
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_snap <= '0;
		end
		else if (state == ST_IDLE && pass_tick)
		begin
			input_snap <= din_sync;
		end
	end

	// Rule word decode, valid while the rule word sits on the read port
	always_comb
	begin
		selected_input_level = input_snap[mem_rd_data[SEL_MSB:SEL_LSB]];
		if (selected_input_level)
		begin
			src_field = mem_rd_data[SRC_HI_MSB:SRC_HI_LSB];
		end
		else
		begin
			src_field = mem_rd_data[SRC_LO_MSB:SRC_LO_LSB];
		end
		dest_field = mem_rd_data[DEST_MSB:DEST_LSB];
		tgt_code = mem_rd_data[TGT_MSB:TGT_LSB];
		group_first = NO_REG;
		dst_addr = NO_REG;
		copy_valid = 1'b0;
		unique case (tgt_code)
			TGT_MODE:
			begin
				group_first = MODE_GROUP_FIRST;
				dst_addr = MODE_REG;
				copy_valid = 1'b1;
			end
			TGT_VELOCITY:
			begin
				group_first = VELOCITY_GROUP_FIRST;
				dst_addr = VELOCITY_SETPOINT_REG;
				copy_valid = 1'b1;
			end
			TGT_POSITION:
			begin
				group_first = POSITION_GROUP_FIRST;
				dst_addr = POSITION_SETPOINT_REG;
				copy_valid = 1'b1;
			end
			TGT_ACCEL:
			begin
				group_first = ACCEL_GROUP_FIRST;
				dst_addr = ACCEL_SETPOINT_REG;
				copy_valid = 1'b1;
			end
			TGT_TORQUE:
			begin
				group_first = TORQUE_GROUP_FIRST;
				dst_addr = TORQUE_SETPOINT_REG;
				copy_valid = 1'b1;
			end
			TGT_INPOS_WIN:
			begin
				group_first = IN_POS_WIN_GROUP_FIRST;
				dst_addr = IN_POSITION_WINDOW_REG;
				copy_valid = 1'b1;
			end
			TGT_ANY_REG:
			begin
				dst_addr = dest_field;
				copy_valid = (dest_field != NO_REG);
			end
			default:
			begin
				copy_valid = 1'b0;
			end
		endcase
		if (tgt_code == TGT_ANY_REG)
		begin
			src_addr = src_field;
		end
		else
		begin
			src_addr = REG_NUM_W'(group_first + src_field - 1'b1);
		end
		if (src_field == NO_REG)
		begin
			copy_valid = 1'b0;
		end
	end

	assign last_rule = (rule_idx == RULE_IDX_W'(RULE_COUNT - 1));

	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (pass_tick)
				begin
					next_state = ST_FETCH;
				end
			end
			ST_FETCH:
			begin
				next_state = ST_DECODE;
			end
			ST_DECODE:
			begin
				if (copy_valid)
				begin
					next_state = ST_COPY;
				end
				else if (last_rule)
				begin
					next_state = ST_IDLE;
				end
				else
				begin
					next_state = ST_FETCH;
				end
			end
			ST_COPY:
			begin
				if (last_rule)
				begin
					next_state = ST_IDLE;
				end
				else
				begin
					next_state = ST_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Rules are taken strictly from first to twelfth
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rule_idx <= '0;
		end
		else if (state == ST_IDLE)
		begin
			rule_idx <= '0;
		end
		else if ((state == ST_DECODE && !copy_valid) || state == ST_COPY)
		begin
			rule_idx <= rule_idx + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			copy_dst <= NO_REG;
			copy_from_inputs <= 1'b0;
		end
		else if (state == ST_DECODE)
		begin
			copy_dst <= dst_addr;
			copy_from_inputs <= (src_addr == DIN_STATE_REG);
		end
	end

	// Engine owns the register space during a pass; APB only while idle
	assign apb_ack_now = psel && penable && !pready && addr_from_apb &&
		(state == ST_IDLE) && !pass_tick;

	always_comb
	begin
		mem_rd_addr = apb_reg;
		mem_wr_en = 1'b0;
		mem_wr_addr = apb_reg;
		mem_wr_data = pwdata;
		unique case (state)
			ST_IDLE:
			begin
				mem_wr_en = apb_ack_now && pwrite && (apb_reg != DIN_STATE_REG);
			end
			ST_FETCH:
			begin
				mem_rd_addr = REG_NUM_W'(RULE_BASE_REG + rule_idx);
			end
			ST_DECODE:
			begin
				mem_rd_addr = src_addr;
			end
			ST_COPY:
			begin
				// Each copy lands at once, so a later rule overwrites an earlier one
				mem_wr_en = (copy_dst != DIN_STATE_REG);
				mem_wr_addr = copy_dst;
				if (copy_from_inputs)
				begin
					mem_wr_data = {{(DATA_W-DIN_W){1'b0}}, input_snap};
				end
				else
				begin
					mem_wr_data = mem_rd_data;
				end
			end
		endcase
	end

	// Read data on the port is the APB address only if it was driven last cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_from_apb <= 1'b0;
		end
		else
		begin
			addr_from_apb <= (state == ST_IDLE);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= REG_RESET;
		end
		else if (apb_ack_now)
		begin
			pready <= 1'b1;
			pslverr <= pwrite && (apb_reg == DIN_STATE_REG);
			if (pwrite)
			begin
				prdata <= prdata; // Writes leave the last read data standing
			end
			else if (apb_reg == DIN_STATE_REG)
			begin
				prdata <= din_word;
			end
			else
			begin
				prdata <= mem_rd_data;
			end
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pass_active <= 1'b0;
		end
		else
		begin
			pass_active <= (next_state != ST_IDLE);
		end
	end

endmodule

`default_nettype wire

// ---- testbench/idrc_copy_engine_checker.sv ----
// Port-level checks of the copy engine: pass timing and APB answers.
// Bound to every copy engine; PASS_CYCLES follows the instance.
`default_nettype none

module idrc_copy_engine_checker
	import idrc_pkg::*;
#(
	parameter int PASS_CYCLES = PASS_PERIOD_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [DIN_W-1:0] digital_inputs,
	input wire logic pass_active
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic act_d;
	int since_rise;
	logic seen_rise;

	// Cycles since the last pass began, for the period check
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_d <= 1'b0;
			since_rise <= 0;
			seen_rise <= 1'b0;
		end
		else
		begin
			act_d <= pass_active;
			if (pass_active && !act_d)
			begin
				since_rise <= 1;
				seen_rise <= 1'b1;
			end
			else
			begin
				since_rise <= since_rise + 1;
			end
		end
	end

	pass_hold_a: assert property ($rose(pass_active) |-> pass_active[*8])
		else $error("pass ended too early");
	pass_len_a: assert property ($rose(pass_active) |-> ##[20:40] $fell(pass_active))
		else $error("pass length out of range");
	pass_period_a: assert property (pass_active && !act_d && seen_rise
		|-> since_rise == PASS_CYCLES)
		else $error("pass period wrong");
	bus_quiet_a: assert property (pass_active |-> !pready)
		else $error("bus answered during a pass");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_wait_a: assert property (psel && penable && !$past(penable) |-> ##[1:48] pready)
		else $error("transfer never answered");
	err_cause_a: assert property (pslverr |-> pready && pwrite && paddr[9:2] == DIN_STATE_REG)
		else $error("pslverr without a write to the input state");
	err_din_a: assert property (pready && pwrite && paddr[9:2] == DIN_STATE_REG |-> pslverr)
		else $error("input state write not refused");
	rdata_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata))
		else $error("prdata moved outside a read answer");
endmodule

bind idrc_copy_engine idrc_copy_engine_checker #(.PASS_CYCLES(PASS_CYCLES)) i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.digital_inputs(digital_inputs),
	.pass_active(pass_active)
);

`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench of the copy engine: APB master and input pins.
// Assumes the pass timer is shortened to 64 cycles.
`default_nettype none

module tb
	import idrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [APB_ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, pass_active, er;
	logic [DIN_W-1:0] din = '0;
	int n_fail = 0, checked = 0;
	logic [7:0] fix_r [6] = '{MODE_REG, VELOCITY_SETPOINT_REG, POSITION_SETPOINT_REG,
		ACCEL_SETPOINT_REG, TORQUE_SETPOINT_REG, IN_POSITION_WINDOW_REG};
	logic [7:0] grp_r [6] = '{MODE_GROUP_FIRST, VELOCITY_GROUP_FIRST, POSITION_GROUP_FIRST,
		ACCEL_GROUP_FIRST, TORQUE_GROUP_FIRST, IN_POS_WIN_GROUP_FIRST};

	idrc_copy_engine #(.PASS_CYCLES(64)) i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.digital_inputs(din),
		.pass_active(pass_active)
	);

	initial forever #5 pclk = ~pclk;

	task close_out();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Setup, access held until pready is sampled high, then release
	task apb(input logic wr_n, input logic [7:0] r, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr_n;
		paddr <= {r, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100)
			n_fail++;
	endtask

	task wr(input logic [7:0] r, input logic [31:0] d);
		apb(1'b1, r, d);
	endtask

	task rdc(input logic [7:0] r, input logic [31:0] exp);
		apb(1'b0, r, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// Two full passes, so the synchronised inputs are surely seen
	task passes();
		int n;
		n = 0;
		repeat (2)
		begin
			while (pass_active !== 1'b1 && n < 400)
			begin
				@(posedge pclk);
				n++;
			end
			while (pass_active !== 1'b0 && n < 400)
			begin
				@(posedge pclk);
				n++;
			end
		end
		if (n >= 400)
			n_fail++;
	endtask

	task t_reset();
		chk({31'h0, pass_active}, 32'h0);
		rdc(RULE_BASE_REG, 32'h0000_0000);
		rdc(RULE_BASE_REG + 8'h0b, 32'h0000_0000);
		din <= 16'ha5c3;
		wr(DIN_STATE_REG, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		rdc(DIN_STATE_REG, 32'h0000_a5c3);
		$display("test reset done");
	endtask

	task t_fixed();
		for (int c = 1; c <= 6; c++)
		begin
			wr(grp_r[c-1] + 8'h01, {28'h100_0000, 4'(c)});
			wr(RULE_BASE_REG, {8'h00, 8'h02, 8'h00, 4'h1, 4'(c)});
			din <= 16'h0002;
			passes();
			rdc(fix_r[c-1], {28'h100_0000, 4'(c)});
		end
		din <= 16'h0000;
		wr(IN_POSITION_WINDOW_REG, 32'h0000_00ee);
		passes();
		rdc(IN_POSITION_WINDOW_REG, 32'h0000_00ee);
		$display("test fixed done");
	endtask

	task t_any();
		wr(8'h91, 32'hcafe_0001);
		wr(8'h92, 32'hbeef_0002);
		wr(RULE_BASE_REG, {8'h90, 8'h91, 8'h92, 4'hf, 4'h7});
		din <= 16'h8000;
		passes();
		rdc(8'h90, 32'hcafe_0001);
		din <= 16'h0000;
		passes();
		rdc(8'h90, 32'hbeef_0002);
		wr(8'h90, 32'h0000_1234);
		passes();
		rdc(8'h90, 32'hbeef_0002);
		wr(RULE_BASE_REG, {8'h00, 8'h91, 8'h92, 4'hf, 4'h7});
		passes();
		rdc(8'h00, 32'h0000_0000);
		$display("test any done");
	endtask

	task t_prio();
		wr(VELOCITY_GROUP_FIRST, 32'h0000_0111);
		wr(VELOCITY_GROUP_FIRST + 8'h01, 32'h0000_0222);
		wr(8'h90, 32'h0000_0000);
		wr(RULE_BASE_REG, {8'h90, 8'h01, 8'h01, 4'h5, 4'h2});
		wr(RULE_BASE_REG + 8'h01, {8'h00, 8'h02, 8'h02, 4'h5, 4'h2});
		wr(RULE_BASE_REG + 8'h02, {8'h90, 8'h91, 8'h92, 4'h5, 4'hf});
		din <= 16'h0020;
		passes();
		rdc(VELOCITY_SETPOINT_REG, 32'h0000_0222);
		rdc(8'h90, 32'h0000_0000);
		$display("test priority done");
	endtask

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fixed();
		t_any();
		t_prio();
		close_out();
	end

	initial
	begin
		#300000;
		n_fail++;
		close_out();
	end
endmodule

`default_nettype wire
